//--- src/soft_reset_consts.vh
/*
 * constants for the i2c soft reset register slave: bus codes, register offset,
 * widths and timing. assumes it is included by bare name from the design files.
 */
`ifndef SOFT_RESET_CONSTS_VH
`define SOFT_RESET_CONSTS_VH

// ************************************************************
// register map
// ************************************************************
`define SRST_REG_ADDR 8'h7c
`define SRST_REG_WIDTH 8
`define BYTE_WIDTH 8
`define ADDR_WIDTH 7
`define SLAVE_ADDR_DEF 7'h3a
`define READ_FILL 8'hff

// ************************************************************
// timing
// ************************************************************
`define SRST_PULSE_CYC 4'h4
`define BIT_CNT_LAST 4'h8
`define BIT_CNT_ZERO 4'h0

`endif

//--- src/pin_sync.v
/*
 * three-flop input synchroniser with agreement filter.
 * assumes the input is asynchronous to clk_sys; output changes only once
 * stages two and three agree.
 */
module pin_sync #(
	parameter RESET_LEVEL = 1'b1
) (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	input wire clk_en,
	// pin
	input wire pin_in,
	output reg pin_out
);

reg s1_r;
reg s2_r;
reg s3_r;

// first stage feeds only the second
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		s1_r <= RESET_LEVEL;
		s2_r <= RESET_LEVEL;
		s3_r <= RESET_LEVEL;
		pin_out <= RESET_LEVEL;
	end else if (clk_en) begin
		s1_r <= pin_in;
		s2_r <= s1_r;
		s3_r <= s2_r;
		if (s2_r == s3_r)
			pin_out <= s3_r;
	end
end

endmodule

//--- src/soft_reset_i2c.v
/*
 * i2c slave front end for the eight-bit software reset register.
 * assumes scl and sda are open-drain pins sampled on clk_sys; the device
 * reset domain consumes soft_rst_pulse and keeps dac data, latch and clear.
 */
`include "soft_reset_consts.vh"

module soft_reset_i2c #(
	parameter [`ADDR_WIDTH-1:0] SLAVE_ADDR = `SLAVE_ADDR_DEF
) (
	// clock, reset, enable
	input wire clk_sys,
	input wire resetn,
	input wire clk_en,
	// i2c pins
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n,
	// device reset
	output reg soft_rst_pulse,
	output reg soft_rst_keep_dac,
	// status
	output reg busy
);

// ************************************************************
// reset and pin conditioning
// ************************************************************
reg rst_a_r;
reg rst_n_r;

always @(posedge clk_sys or negedge resetn) begin
	if (!resetn) begin
		rst_a_r <= 1'b0;
		rst_n_r <= 1'b0;
	end else begin
		rst_a_r <= 1'b1;
		rst_n_r <= rst_a_r;
	end
end

wire scl_s;
wire sda_s;

pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
	.clk_sys(clk_sys),
	.rst_n(rst_n_r),
	.clk_en(clk_en),
	.pin_in(scl_in),
	.pin_out(scl_s)
);

pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
	.clk_sys(clk_sys),
	.rst_n(rst_n_r),
	.clk_en(clk_en),
	.pin_in(sda_in),
	.pin_out(sda_s)
);

reg scl_d_r;
reg sda_d_r;

wire scl_rise = scl_s & ~scl_d_r;
wire scl_fall = ~scl_s & scl_d_r;
wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

// ************************************************************
// byte state machine
// ************************************************************
localparam [5:0] ST_IDLE = 6'b000001;
localparam [5:0] ST_DEVADDR = 6'b000010;
localparam [5:0] ST_REGADDR = 6'b000100;
localparam [5:0] ST_WDATA = 6'b001000;
localparam [5:0] ST_RDATA = 6'b010000;
localparam [5:0] ST_ACK = 6'b100000;

reg [5:0] state_r;
reg [5:0] state_nxt;
reg [5:0] after_ack_r;
reg [5:0] after_ack_nxt;
reg [3:0] bit_cnt_r;
reg [3:0] bit_cnt_nxt;
reg [`BYTE_WIDTH-1:0] shift_r;
reg [`BYTE_WIDTH-1:0] shift_nxt;
reg reg_hit_r;
reg reg_hit_nxt;
reg fire_r;
reg fire_nxt;
reg drive_r;
reg drive_nxt;
reg [3:0] pulse_cnt_r;
wire [`BYTE_WIDTH-1:0] shift_in = {shift_r[`BYTE_WIDTH-2:0], sda_s};
// fill byte lined up so that its msb is the bit now due on the wire
wire [`BYTE_WIDTH-1:0] fill_sh = `READ_FILL << bit_cnt_r;

always @* begin
	state_nxt = state_r;
	after_ack_nxt = after_ack_r;
	bit_cnt_nxt = bit_cnt_r;
	shift_nxt = shift_r;
	reg_hit_nxt = reg_hit_r;
	// fire is held through the whole ack so the pulse waits for the ack clock to fall
	fire_nxt = fire_r;
	drive_nxt = drive_r;
	if (start_det) begin
		// repeated start aborts any pending byte without a reset
		state_nxt = ST_DEVADDR;
		bit_cnt_nxt = `BIT_CNT_ZERO;
		drive_nxt = 1'b0;
		reg_hit_nxt = 1'b0;
		fire_nxt = 1'b0;
	end else if (stop_det) begin
		state_nxt = ST_IDLE;
		drive_nxt = 1'b0;
		fire_nxt = 1'b0;
	end else begin
		case (state_r)
		ST_IDLE: begin
			drive_nxt = 1'b0;
		end
		ST_DEVADDR, ST_REGADDR, ST_WDATA: begin
			if (scl_rise) begin
				shift_nxt = shift_in;
				bit_cnt_nxt = bit_cnt_r + 4'h1;
			end
			if (scl_fall && bit_cnt_r == `BIT_CNT_LAST) begin
				bit_cnt_nxt = `BIT_CNT_ZERO;
				state_nxt = ST_ACK;
				drive_nxt = 1'b1;
				after_ack_nxt = ST_IDLE;
				if (state_r == ST_DEVADDR) begin
					if (shift_r[`BYTE_WIDTH-1:1] != SLAVE_ADDR) begin
						state_nxt = ST_IDLE;
						drive_nxt = 1'b0;
					end else if (shift_r[0])
						after_ack_nxt = ST_RDATA;
					else
						after_ack_nxt = ST_REGADDR;
				end else if (state_r == ST_REGADDR) begin
					reg_hit_nxt = (shift_r == `SRST_REG_ADDR);
					after_ack_nxt = ST_WDATA;
				end else begin
					// any value counts; only one byte accepted per access
					fire_nxt = reg_hit_r;
					after_ack_nxt = ST_IDLE;
				end
			end
		end
		ST_ACK: begin
			if (scl_fall) begin
				// the pulse is launched from fire_r in this very cycle
				fire_nxt = 1'b0;
				drive_nxt = 1'b0;
				state_nxt = after_ack_r;
				if (after_ack_r == ST_RDATA)
					drive_nxt = ~fill_sh[`BYTE_WIDTH-1];
			end
		end
		ST_RDATA: begin
			// undefined fill byte msb first; the ninth slot is left to the master
			if (scl_rise)
				bit_cnt_nxt = bit_cnt_r + 4'h1;
			if (scl_fall) begin
				if (bit_cnt_r < `BIT_CNT_LAST)
					drive_nxt = ~fill_sh[`BYTE_WIDTH-1];
				else
					drive_nxt = 1'b0;
				if (bit_cnt_r > `BIT_CNT_LAST) begin
					bit_cnt_nxt = `BIT_CNT_ZERO;
					state_nxt = ST_IDLE;
				end
			end
		end
		default: begin
			state_nxt = ST_IDLE;
			drive_nxt = 1'b0;
		end
		endcase
	end
end

always @(posedge clk_sys or negedge rst_n_r) begin
	if (!rst_n_r) begin
		state_r <= ST_IDLE;
		after_ack_r <= ST_IDLE;
		bit_cnt_r <= `BIT_CNT_ZERO;
		shift_r <= 8'h00;
		reg_hit_r <= 1'b0;
		fire_r <= 1'b0;
		drive_r <= 1'b0;
		scl_d_r <= 1'b1;
		sda_d_r <= 1'b1;
	end else if (clk_en) begin
		state_r <= state_nxt;
		after_ack_r <= after_ack_nxt;
		bit_cnt_r <= bit_cnt_nxt;
		shift_r <= shift_nxt;
		reg_hit_r <= reg_hit_nxt;
		fire_r <= fire_nxt;
		drive_r <= drive_nxt;
		scl_d_r <= scl_s;
		sda_d_r <= sda_s;
	end
end

// ************************************************************
// outputs
// ************************************************************
// fire_r waits until the ack clock falls, so the ack is complete first
always @(posedge clk_sys or negedge rst_n_r) begin
	if (!rst_n_r) begin
		pulse_cnt_r <= 4'h0;
		soft_rst_pulse <= 1'b0;
		soft_rst_keep_dac <= 1'b0;
		sda_out <= 1'b0;
		sda_oe_n <= 1'b1;
		busy <= 1'b0;
	end else if (clk_en) begin
		if (fire_r && state_r == ST_ACK && scl_fall)
			pulse_cnt_r <= `SRST_PULSE_CYC;
		else if (pulse_cnt_r != 4'h0)
			pulse_cnt_r <= pulse_cnt_r - 4'h1;
		soft_rst_pulse <= (pulse_cnt_r != 4'h0);
		soft_rst_keep_dac <= (pulse_cnt_r != 4'h0);
		sda_out <= 1'b0;
		sda_oe_n <= ~drive_r;
		busy <= (state_r != ST_IDLE);
	end
end

endmodule

//--- sim/soft_reset_i2c_sva.sv
/*
 * checker for the soft reset i2c slave.
 * assumes scl phases last far longer than the pin synchroniser delay.
 */
// ****
// assertions
// ****
module soft_reset_i2c_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// i2c pins
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	// device reset
	input wire logic soft_rst_pulse,
	input wire logic soft_rst_keep_dac
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence pulse_held;
		soft_rst_pulse [*4] ##1 !soft_rst_pulse;
	endsequence
	AST_KEEP_DAC: assert property (soft_rst_keep_dac == soft_rst_pulse)
		else $error("keep dac differs");
	AST_PULSE_LEN: assert property ($rose(soft_rst_pulse) |-> pulse_held)
		else $error("pulse length");
	AST_PULSE_SCL: assert property ($rose(soft_rst_pulse) |-> !scl_in)
		else $error("pulse off ack");
	AST_PULSE_GAP: assert property ($fell(soft_rst_pulse) |-> !soft_rst_pulse [*8])
		else $error("pulse refired");
	AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
		else $error("sda driven high");
	AST_ACK_EDGE: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("sda moved in scl high");
	AST_ACK_HOLD: assert property ($fell(sda_oe_n) |-> ##1 !sda_oe_n [*8])
		else $error("ack short");
	AST_RESET_IDLE: assert property (disable iff (1'b0) !resetn ##1 !resetn |-> sda_oe_n && !soft_rst_pulse)
		else $error("active in reset");
endmodule
bind soft_reset_i2c soft_reset_i2c_sva i_soft_reset_i2c_sva (.clk_sys(clk_sys), .resetn(resetn), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .soft_rst_pulse(soft_rst_pulse), .soft_rst_keep_dac(soft_rst_keep_dac));

//--- sim/i2c_master_model.sv
/*
 * i2c master model, open drain scl and sda.
 * assumes the bench resolves sda_bus with a pull-up.
 */
module i2c_master_model (
	// clock
	input wire logic clk_sys,
	// bus
	input wire logic sda_bus,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// bus cycles
	// ****
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic ph();
		repeat (20) @(negedge clk_sys);
	endtask
	task automatic start();
		sda = 1'b0;
		ph();
		scl = 1'b0;
		ph();
	endtask
	task automatic stop();
		sda = 1'b0;
		ph();
		scl = 1'b1;
		ph();
		sda = 1'b1;
		ph();
	endtask
	// ack slot released so the device can pull it; data moves a phase after scl falls
	task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
		logic [8:0] tx, rx;
		tx = {d, 1'b1};
		for (int i = 8; i >= 0; i--) begin
			sda = tx[i];
			ph();
			scl = 1'b1;
			ph();
			rx[i] = sda_bus;
			scl = 1'b0;
			ph();
		end
		r = rx[8:1];
		ack = !rx[0];
	endtask
endmodule

//--- sim/tb.sv
/*
 * self-checking bench for the soft reset i2c slave.
 * assumes the master model and checker are compiled first.
 */
`include "soft_reset_consts.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// bench
	// ****
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic scl, sda_m, sda_out, sda_oe_n, soft_rst_pulse, soft_rst_keep_dac, busy, a;
	logic [31:0] seed = 32'h0000_36bc;
	logic [7:0] r;
	logic [7:0] exp_q[$];
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	wire sda_bus = sda_m & (sda_oe_n | sda_out);
	localparam logic [7:0] WR = {`SLAVE_ADDR_DEF, 1'b0};
	initial forever #2.5 clk_sys = ~clk_sys;
	soft_reset_i2c i_soft_reset_i2c (.clk_sys, .resetn, .clk_en(1'b1), .scl_in(scl), .sda_in(sda_bus),
		.sda_out, .sda_oe_n, .soft_rst_pulse, .soft_rst_keep_dac, .busy);
	i2c_master_model i_i2c_master_model (.clk_sys, .sda_bus, .scl, .sda(sda_m));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic give_verdict();
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// em masks the acks that the device leaves unspecified
	task automatic txn(input logic [7:0] sa, ra, d, input int n, input logic [3:0] ea, em);
		logic [31:0] v;
		v = {sa, ra, d, d};
		i_i2c_master_model.start();
		chk("busy", 8'h01, {7'h00, busy});
		for (int i = 0; i < n; i++) begin
			i_i2c_master_model.xfer(v[31-8*i -: 8], r, a);
			if (em[i])
				chk("ack", {7'h00, ea[i]}, {7'h00, a});
		end
		i_i2c_master_model.stop();
		chk("busy", 8'h00, {7'h00, busy});
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if ($rose(soft_rst_pulse))
			chk("reset pulse", exp_q.size() ? exp_q.pop_front() : 8'h00, 8'h01);
		if (cyc == 40000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		repeat (4) @(negedge clk_sys);
		resetn = 1'b1;
		repeat (10) @(negedge clk_sys);
		for (int k = 0; k < 3; k++) begin
			exp_q.push_back(8'h01);
			txn(WR, `SRST_REG_ADDR, rnd(), 3, 4'h7, 4'h7);
		end
		exp_q.push_back(8'h01);
		txn(WR, `SRST_REG_ADDR, rnd(), 4, 4'h7, 4'hf);
		txn(WR, rnd() | 8'h80, rnd(), 3, 4'h3, 4'h3);
		txn(WR ^ 8'h02, `SRST_REG_ADDR, rnd(), 3, 4'h0, 4'h1);
		txn(WR, `SRST_REG_ADDR, rnd(), 2, 4'h3, 4'h3);
		txn(WR | 8'h01, 8'hff, 8'hff, 2, 4'h1, 4'h1);
		chk("read byte", `READ_FILL, r);
		repeat (50) @(negedge clk_sys);
		chk("pending pulses", 8'h00, 8'(exp_q.size()));
		give_verdict();
	end
endmodule
